// file: bench/nfcev_top_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module nfcev_top_test import nfcev_pkg::*;;
  // ****************************************************************
  // signals and design instance
  // ****************************************************************
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [NUM_EVT-1:0] ev = '0;
  logic task_a;
  logic sense;
  logic rxen;
  logic irq;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;

  always #25 clk = ~clk;

  nfcev_top #(.ADDR_W(12)) dut (
    .clk_in(clk),
    .rst_b_in(rst_b),
    .addr_in(addr),
    .wdata_in(wdata),
    .wr_in(wr),
    .rd_in(rd),
    .rdata_out(rdata),
    .ready_event_in(ev[EV_READY]),
    .field_detected_event_in(ev[EV_FIELD_DET]),
    .field_lost_event_in(ev[EV_FIELD_LOST]),
    .tx_frame_start_event_in(ev[EV_TX_START]),
    .tx_frame_end_event_in(ev[EV_TX_END]),
    .rx_frame_start_event_in(ev[EV_RX_START]),
    .rx_frame_end_event_in(ev[EV_RX_END]),
    .error_event_in(ev[EV_ERROR]),
    .rx_frame_error_event_in(ev[EV_RX_ERROR]),
    .rx_buffer_full_event_in(ev[EV_RX_FULL]),
    .dma_ready_event_in(ev[EV_DMA_READY]),
    .task_a_out(task_a),
    .sense_task_out(sense),
    .rx_enable_task_out(rxen),
    .irq_out(irq)
  );

  // ****************************************************************
  // bus and event helpers
  // ****************************************************************
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe, so sample it there
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // returns just after the edge that took the pulse
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
    #1;
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset_values();
    logic [31:0] d;
    rd_reg(OFS_DMA_READY, d);
    `CHK(d, RST_EVENT)
    rd_reg(OFS_LINKS, d);
    `CHK(d, RST_LINKS)
    rd_reg(OFS_MASK, d);
    `CHK(d, RST_MASK)
    `CHK(irq, 1'b0)
  endtask

  // unimplemented bits read 0; an unmapped write must not touch the mask
  task automatic t_reg_access();
    logic [31:0] d;
    wr_reg(OFS_MASK, 32'hFFFFFFFF);
    rd_reg(OFS_MASK, d);
    `CHK(d, 32'h00100CFF)
    wr_reg(12'h304, 32'h00000000);
    rd_reg(OFS_MASK, d);
    `CHK(d, 32'h00100CFF)
    rd_reg(12'h304, d);
    `CHK(d, 32'h00000000)
    wr_reg(OFS_MASK, 32'h00000000);
    wr_reg(OFS_LINKS, 32'hFFFFFFFF);
    rd_reg(OFS_LINKS, d);
    `CHK(d, 32'h00000023)
    wr_reg(OFS_LINKS, 32'h00000000);
    rd_reg(OFS_LINKS, d);
    `CHK(d, 32'h00000000)
  endtask

  // each event held back by its mask bit, then let through, then withdrawn
  task automatic t_events();
    logic [31:0] d;
    logic [31:0] m;
    for (int i = 0; i < NUM_EVT; i++) begin
      m = 32'h00000001 << EVT_MASK_BIT[i];
      wr_reg(OFS_MASK, ~m);
      pulse(i);
      repeat (2) @(posedge clk);
      #1;
      `CHK(irq, 1'b0)
      rd_reg(EVT_OFS[i], d);
      `CHK(d, 32'h00000001)
      wr_reg(OFS_MASK, m);
      @(posedge clk);
      #1;
      `CHK(irq, 1'b1)
      rd_reg(OFS_MASK, d);
      `CHK(d, m)
      wr_reg(EVT_OFS[i], 32'h00000000);
      @(posedge clk);
      #1;
      `CHK(irq, 1'b0)
      rd_reg(EVT_OFS[i], d);
      `CHK(d, 32'h00000000)
    end
    wr_reg(OFS_MASK, 32'h00000000);
  endtask

  // each link fires only its own task, one cycle, only while enabled
  task automatic t_links();
    int evs [3];
    int bits [3];
    evs = '{EV_FIELD_DET, EV_FIELD_LOST, EV_TX_END};
    bits = '{LINK_FIELD_ON_BIT, LINK_FIELD_OFF_BIT, LINK_TX_DONE_BIT};
    for (int k = 0; k < 3; k++) begin
      wr_reg(OFS_LINKS, ~(32'h00000001 << bits[k]));
      pulse(evs[k]);
      `CHK({rxen, sense, task_a}, 3'b000)
      wr_reg(OFS_LINKS, 32'h00000001 << bits[k]);
      pulse(evs[k]);
      `CHK({rxen, sense, task_a}, 3'b001 << k)
      @(posedge clk);
      #1;
      `CHK({rxen, sense, task_a}, 3'b000)
      wr_reg(EVT_OFS[evs[k]], 32'h00000000);
    end
    wr_reg(OFS_LINKS, 32'h00000000);
  endtask

  // a read right behind a write sees it; an event beats a write of 0 in its cycle
  task automatic t_same_cycle();
    logic [31:0] d;
    @(posedge clk);
    addr <= OFS_MASK;
    wdata <= 32'h00000002;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, 32'h00000002)
    @(posedge clk);
    addr <= OFS_FIELD_DET;
    wdata <= 32'h00000000;
    wr <= 1'b1;
    ev[EV_FIELD_DET] <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    ev[EV_FIELD_DET] <= 1'b0;
    rd_reg(OFS_FIELD_DET, d);
    `CHK(d, 32'h00000001)
    `CHK(irq, 1'b1)
    wr_reg(OFS_FIELD_DET, 32'h00000000);
    @(posedge clk);
    #1;
    `CHK(irq, 1'b0)
    wr_reg(OFS_DMA_READY, 32'h00000001);
    rd_reg(OFS_DMA_READY, d);
    `CHK(d, 32'h00000001)
    wr_reg(OFS_DMA_READY, 32'h00000000);
    wr_reg(OFS_MASK, 32'h00000000);
  endtask

  // a reset in mid-run must bring the error, link and mask registers back to their reset values
  task automatic t_mid_reset();
    logic [31:0] d;
    wr_reg(OFS_LINKS, 32'h00000023);
    wr_reg(OFS_MASK, 32'h00100CFF);
    pulse(EV_ERROR);
    @(posedge clk);
    #1;
    `CHK(irq, 1'b1)
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK(irq, 1'b0)
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(OFS_ERROR, d);
    `CHK(d, RST_EVENT)
    rd_reg(OFS_LINKS, d);
    `CHK(d, RST_LINKS)
    rd_reg(OFS_MASK, d);
    `CHK(d, RST_MASK)
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset_values();
    t_reg_access();
    t_events();
    t_links();
    t_same_cycle();
    t_mid_reset();
    repeat (2) @(posedge clk);
    stop_test();
  end
endmodule
`default_nettype wire

// file: hdl/nfcev_event_flag.sv
`timescale 1ns/100ps
`default_nettype none
module nfcev_event_flag (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // event source and software access
  input wire logic set_in,
  input wire logic wr_in,
  input wire logic wdata_in,
  // stored flag
  output logic flag_out
);
  typedef struct packed {
    logic flag;
  } nfcev_flag_state_t;

  nfcev_flag_state_t s_q;
  nfcev_flag_state_t s_d;

  // a hardware event beats a software write in the same cycle, so none is lost
  always_comb begin
    s_d = s_q;
    if (set_in) begin
      s_d.flag = 1'b1;
    end else if (wr_in) begin
      s_d.flag = wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flag_out = s_q.flag;
endmodule
`default_nettype wire

// file: hdl/nfcev_pkg.sv
// Notes on behaviour
// - the dma-ready event register reads 1 once the transfer engine reports ready, else 0.
// - the event_task_links register enables each event-to-task link by a 1, and resets to zero.
// - with field_on_to_task_a_link set, every field_detected_event fires task_a by itself.
// - with field_off_to_sense_link set, every field_lost_event fires the sense task by itself.
// - with tx_done_to_rx_enable_link set, every tx_frame_end_event fires rx_enable_task.
// - interrupt_enable_mask is read-write, one bit per event, 1 enables, reset value zero.
// - bit 0 of the mask gates the peripheral-ready event onto the interrupt.
// - the mask holds its own bit for field_detected_event.
// - the mask holds its own bit for field_lost_event.
// - the mask holds separate bits for tx_frame_start_event and tx_frame_end_event.
// - the mask holds separate bits for rx_frame_start_event and rx_frame_end_event.
// - the mask holds a bit for the general error event.
// - the mask holds a bit for rx_frame_error_event apart from the general error bit.
// - the mask holds a bit for rx_buffer_full_event.
package nfcev_pkg;

  // ****************************************************************
  // event registers
  // ****************************************************************
  localparam int NUM_EVT = 11;
  localparam logic [11:0] OFS_READY = 12'h100;
  localparam logic [11:0] OFS_FIELD_DET = 12'h104;
  localparam logic [11:0] OFS_FIELD_LOST = 12'h108;
  localparam logic [11:0] OFS_TX_START = 12'h10C;
  localparam logic [11:0] OFS_TX_END = 12'h110;
  localparam logic [11:0] OFS_RX_START = 12'h114;
  localparam logic [11:0] OFS_RX_END = 12'h118;
  localparam logic [11:0] OFS_ERROR = 12'h11C;
  localparam logic [11:0] OFS_RX_ERROR = 12'h128;
  localparam logic [11:0] OFS_RX_FULL = 12'h12C;
  localparam logic [11:0] OFS_DMA_READY = 12'h150;

  // index of each event inside the flag vector
  localparam int EV_READY = 0;
  localparam int EV_FIELD_DET = 1;
  localparam int EV_FIELD_LOST = 2;
  localparam int EV_TX_START = 3;
  localparam int EV_TX_END = 4;
  localparam int EV_RX_START = 5;
  localparam int EV_RX_END = 6;
  localparam int EV_ERROR = 7;
  localparam int EV_RX_ERROR = 8;
  localparam int EV_RX_FULL = 9;
  localparam int EV_DMA_READY = 10;

  localparam logic [11:0] EVT_OFS [NUM_EVT] = '{OFS_READY, OFS_FIELD_DET, OFS_FIELD_LOST,
    OFS_TX_START, OFS_TX_END, OFS_RX_START, OFS_RX_END, OFS_ERROR, OFS_RX_ERROR,
    OFS_RX_FULL, OFS_DMA_READY};
  // bit position of each event inside interrupt_enable_mask
  localparam int EVT_MASK_BIT [NUM_EVT] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 11, 20};

  // ****************************************************************
  // link and mask registers
  // ****************************************************************
  localparam logic [11:0] OFS_LINKS = 12'h200;
  localparam logic [11:0] OFS_MASK = 12'h300;
  localparam int LINK_FIELD_ON_BIT = 0;
  localparam int LINK_FIELD_OFF_BIT = 1;
  localparam int LINK_TX_DONE_BIT = 5;
  localparam logic [31:0] RST_EVENT = 32'h00000000;
  localparam logic [31:0] RST_LINKS = 32'h00000000;
  localparam logic [31:0] RST_MASK = 32'h00000000;

endpackage

// file: hdl/nfcev_reset_sync.sv
`timescale 1ns/100ps
`default_nettype none
module nfcev_reset_sync (
  // clock and raw reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // released reset
  output logic rst_b_out
);
  typedef struct packed {
    logic meta;
    logic done;
  } nfcev_rsync_state_t;

  nfcev_rsync_state_t s_q;
  nfcev_rsync_state_t s_d;

  always_comb begin
    s_d.meta = 1'b1;
    s_d.done = s_q.meta;
  end

  // assert at once, release only after two clean edges
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rst_b_out = s_q.done;
endmodule
`default_nettype wire

// file: hdl/nfcev_top.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module nfcev_top
  import nfcev_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // register port
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // events from the tag logic, one-cycle pulses
  input wire logic ready_event_in,
  input wire logic field_detected_event_in,
  input wire logic field_lost_event_in,
  input wire logic tx_frame_start_event_in,
  input wire logic tx_frame_end_event_in,
  input wire logic rx_frame_start_event_in,
  input wire logic rx_frame_end_event_in,
  input wire logic error_event_in,
  input wire logic rx_frame_error_event_in,
  input wire logic rx_buffer_full_event_in,
  input wire logic dma_ready_event_in,
  // tasks to the tag logic, one-cycle pulses
  output logic task_a_out,
  output logic sense_task_out,
  output logic rx_enable_task_out,
  // interrupt
  output logic irq_out
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  generate
    if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
      $error("nfcev_top: ADDR_W must lie between 10 and 32");
    end
  endgenerate

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_b;

  nfcev_reset_sync u_rsync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .rst_b_out(rst_b)
  );

  // ****************************************************************
  // address decode
  // ****************************************************************
  // upper address bits beyond the map must be zero, so aliases do not appear
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    logic [31:0] wide;
    wide = 32'(a);
    return (wide == {20'h00000, ofs});
  endfunction

  logic links_wr;
  logic mask_wr;
  logic [NUM_EVT-1:0] evt_wr;

  assign links_wr = wr_in && addr_hit(addr_in, OFS_LINKS);
  assign mask_wr = wr_in && addr_hit(addr_in, OFS_MASK);

  // ****************************************************************
  // event registers
  // ****************************************************************
  logic [NUM_EVT-1:0] evt_set;
  logic [NUM_EVT-1:0] evt_flag;

  assign evt_set[EV_READY] = ready_event_in;
  assign evt_set[EV_FIELD_DET] = field_detected_event_in;
  assign evt_set[EV_FIELD_LOST] = field_lost_event_in;
  assign evt_set[EV_TX_START] = tx_frame_start_event_in;
  assign evt_set[EV_TX_END] = tx_frame_end_event_in;
  assign evt_set[EV_RX_START] = rx_frame_start_event_in;
  assign evt_set[EV_RX_END] = rx_frame_end_event_in;
  assign evt_set[EV_ERROR] = error_event_in;
  assign evt_set[EV_RX_ERROR] = rx_frame_error_event_in;
  assign evt_set[EV_RX_FULL] = rx_buffer_full_event_in;
  assign evt_set[EV_DMA_READY] = dma_ready_event_in;

  generate
    for (genvar i = 0; i < NUM_EVT; i++) begin : g_evt
      assign evt_wr[i] = wr_in && addr_hit(addr_in, EVT_OFS[i]);

      // writing 0 withdraws the event, writing 1 raises it by software
      nfcev_event_flag u_flag (
        .clk_in(clk_in),
        .rst_b_in(rst_b),
        .set_in(evt_set[i]),
        .wr_in(evt_wr[i]),
        .wdata_in(wdata_in[0]),
        .flag_out(evt_flag[i])
      );
    end
  endgenerate

  // ****************************************************************
  // register state
  // ****************************************************************
  typedef struct packed {
    logic link_field_on;
    logic link_field_off;
    logic link_tx_done;
    logic [NUM_EVT-1:0] ena;
    logic [31:0] rdata;
    logic task_a;
    logic sense;
    logic rx_en;
    logic irq;
  } nfcev_top_state_t;

  nfcev_top_state_t s_q;
  nfcev_top_state_t s_d;

  // mask image as software sees it, undefined bits read as zero
  logic [31:0] mask_image;
  logic [31:0] links_image;
  logic [31:0] rd_word;

  always_comb begin
    mask_image = RST_MASK;
    for (int i = 0; i < NUM_EVT; i++) begin
      mask_image[EVT_MASK_BIT[i]] = s_q.ena[i];
    end
  end

  always_comb begin
    links_image = RST_LINKS;
    links_image[LINK_FIELD_ON_BIT] = s_q.link_field_on;
    links_image[LINK_FIELD_OFF_BIT] = s_q.link_field_off;
    links_image[LINK_TX_DONE_BIT] = s_q.link_tx_done;
  end

  // unmapped reads return zero rather than holding the last word
  always_comb begin
    rd_word = 32'h00000000;
    if (addr_hit(addr_in, OFS_LINKS)) begin
      rd_word = links_image;
    end else if (addr_hit(addr_in, OFS_MASK)) begin
      rd_word = mask_image;
    end else begin
      for (int i = 0; i < NUM_EVT; i++) begin
        if (addr_hit(addr_in, EVT_OFS[i])) begin
          rd_word = {31'h00000000, evt_flag[i]};
        end
      end
    end
  end

  always_comb begin
    s_d = s_q;
    if (links_wr) begin
      s_d.link_field_on = wdata_in[LINK_FIELD_ON_BIT];
      s_d.link_field_off = wdata_in[LINK_FIELD_OFF_BIT];
      s_d.link_tx_done = wdata_in[LINK_TX_DONE_BIT];
    end
    if (mask_wr) begin
      for (int i = 0; i < NUM_EVT; i++) begin
        s_d.ena[i] = wdata_in[EVT_MASK_BIT[i]];
      end
    end
    // read data stand for exactly one cycle after the strobe
    s_d.rdata = rd_in ? rd_word : 32'h00000000;
    // links act on the raw event pulse, one cycle of latency into the task
    s_d.task_a = s_q.link_field_on && field_detected_event_in;
    s_d.sense = s_q.link_field_off && field_lost_event_in;
    s_d.rx_en = s_q.link_tx_done && tx_frame_end_event_in;
    // registered so the line cannot glitch while flags and mask settle
    s_d.irq = |(evt_flag & s_q.ena);
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rdata_out = s_q.rdata;
  assign task_a_out = s_q.task_a;
  assign sense_task_out = s_q.sense;
  assign rx_enable_task_out = s_q.rx_en;
  assign irq_out = s_q.irq;

  // ****************************************************************
  // assertions
  // ****************************************************************
  // the flag is sticky: only a software write may take it down
  property p_dma_ready_set;
    @(posedge clk_in) disable iff (!rst_b)
    (evt_flag[EV_DMA_READY] && !evt_wr[EV_DMA_READY]) |=> evt_flag[EV_DMA_READY];
  endproperty
  a_dma_ready_set: assert property (p_dma_ready_set) else $error("dma ready flag lost");

  property p_dma_ready_flag;
    @(posedge clk_in) disable iff (!rst_b)
    dma_ready_event_in |=> evt_flag[EV_DMA_READY];
  endproperty
  a_dma_ready_flag: assert property (p_dma_ready_flag) else $error("dma ready not held");

  property p_flag_read;
    @(posedge clk_in) disable iff (!rst_b)
    (rd_in && addr_hit(addr_in, OFS_DMA_READY)) |=>
      (rdata_out == {31'h00000000, $past(evt_flag[EV_DMA_READY])});
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("event read wrong");

  property p_links_write;
    @(posedge clk_in) disable iff (!rst_b)
    links_wr |=> (links_image == ($past(wdata_in) & 32'h00000023));
  endproperty
  a_links_write: assert property (p_links_write) else $error("links not stored");

  property p_task_a;
    @(posedge clk_in) disable iff (!rst_b)
    (field_detected_event_in && s_q.link_field_on) |=> task_a_out ##1
      (task_a_out == $past(field_detected_event_in && s_q.link_field_on));
  endproperty
  a_task_a: assert property (p_task_a) else $error("task_a not fired");

  property p_task_a_quiet;
    @(posedge clk_in) disable iff (!rst_b)
    !(field_detected_event_in && s_q.link_field_on) |=> !task_a_out;
  endproperty
  a_task_a_quiet: assert property (p_task_a_quiet) else $error("stray task_a");

  property p_sense;
    @(posedge clk_in) disable iff (!rst_b)
    sense_task_out == $past(field_lost_event_in && s_q.link_field_off);
  endproperty
  a_sense: assert property (p_sense) else $error("sense task wrong");

  property p_rx_enable;
    @(posedge clk_in) disable iff (!rst_b)
    (tx_frame_end_event_in && links_image[LINK_TX_DONE_BIT]) |=> rx_enable_task_out;
  endproperty
  a_rx_enable: assert property (p_rx_enable) else $error("rx enable not fired");

  property p_rx_enable_quiet;
    @(posedge clk_in) disable iff (!rst_b)
    !(tx_frame_end_event_in && s_q.link_tx_done) |=> !rx_enable_task_out;
  endproperty
  a_rx_enable_quiet: assert property (p_rx_enable_quiet) else $error("stray rx enable");

  property p_links_hold;
    @(posedge clk_in) disable iff (!rst_b)
    !links_wr |=> $stable(links_image);
  endproperty
  a_links_hold: assert property (p_links_hold) else $error("links moved without write");

  property p_links_read;
    @(posedge clk_in) disable iff (!rst_b)
    (rd_in && addr_hit(addr_in, OFS_LINKS)) |=>
      ((rdata_out & ~32'h00000023) == 32'h00000000);
  endproperty
  a_links_read: assert property (p_links_read) else $error("undefined link bit read 1");

  property p_mask_read;
    @(posedge clk_in) disable iff (!rst_b)
    (mask_wr ##1 (rd_in && addr_hit(addr_in, OFS_MASK) && !mask_wr)) |=>
      (rdata_out == ($past(wdata_in, 2) & 32'h00100CFF));
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read back wrong");

  property p_mask_hold;
    @(posedge clk_in) disable iff (!rst_b)
    !mask_wr |=> $stable(s_q.ena);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask moved without write");

  property p_mask_unused;
    @(posedge clk_in) disable iff (!rst_b)
    (rd_in && addr_hit(addr_in, OFS_MASK)) |=>
      ((rdata_out & ~32'h00100CFF) == 32'h00000000);
  endproperty
  a_mask_unused: assert property (p_mask_unused) else $error("undefined mask bit read 1");

  generate
    for (genvar i = 0; i < NUM_EVT; i++) begin : g_evt_chk
      property p_evt_irq;
        @(posedge clk_in) disable iff (!rst_b)
        (evt_flag[i] && s_q.ena[i]) |=> irq_out;
      endproperty
      a_evt_irq: assert property (p_evt_irq) else $error("enabled event gave no irq");

      property p_evt_masked;
        @(posedge clk_in) disable iff (!rst_b)
        (evt_flag == (NUM_EVT'(1) << i) && !s_q.ena[i]) |=> !irq_out;
      endproperty
      a_evt_masked: assert property (p_evt_masked) else $error("masked event gave irq");

      property p_evt_set;
        @(posedge clk_in) disable iff (!rst_b)
        evt_set[i] |=> evt_flag[i];
      endproperty
      a_evt_set: assert property (p_evt_set) else $error("event pulse not stored");

      property p_flag_write;
        @(posedge clk_in) disable iff (!rst_b)
        (evt_wr[i] && !evt_set[i]) |=> (evt_flag[i] == $past(wdata_in[0]));
      endproperty
      a_flag_write: assert property (p_flag_write) else $error("event write not stored");
    end
  endgenerate

  property p_irq_level;
    @(posedge clk_in) disable iff (!rst_b)
    irq_out == $past(|(evt_flag & s_q.ena));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq does not follow flags");

  property p_clear;
    @(posedge clk_in) disable iff (!rst_b)
    (evt_wr[EV_FIELD_DET] && !wdata_in[0] && !field_detected_event_in) |=>
      !evt_flag[EV_FIELD_DET] ##1 (!irq_out || $past(|(evt_flag & s_q.ena)));
  endproperty
  a_clear: assert property (p_clear) else $error("event write of 0 did not clear");

  property p_rdata_idle;
    @(posedge clk_in) disable iff (!rst_b)
    !rd_in |=> (rdata_out == 32'h00000000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");

  // event registers carry their flag in bit 0 only, unmapped words read zero
  property p_rdata_event;
    @(posedge clk_in) disable iff (!rst_b)
    (rd_in && !addr_hit(addr_in, OFS_LINKS) && !addr_hit(addr_in, OFS_MASK)) |=>
      (rdata_out[31:1] == 31'h00000000);
  endproperty
  a_rdata_event: assert property (p_rdata_event) else $error("event read upper bits set");

endmodule
`default_nettype wire
